// file: load_instr_operand_decode.sv
// What this block does
// - Bit field is binary index of bit
// - Two-bit condition: NZ, Z, NC, C
// - Three-bit condition adds LZ, LO, P, M
// - Logical zero/one from flag bit 2 (LV)
// - Displacement is signed, added to base
// - Destination word field: BC DE HL SP
// - Alternate word field: BC' DE' HL', 11 undefined
// - Relative branch adds signed byte to PC
// - Byte field B C D E H L A
// - Source word field: BC DE HL SP
// - Restart codes map to 0000h..0070h
// - First index table: BC DE IX SP
// - Second index table: BC DE IY SP
// - Push/pop table: BC DE HL AF
// - Constant byte n is low byte
// - Store HL immediate, low first, 13 clocks
// - Store index immediate, low first, 15 clocks
// - Store word immediate, low first, 15 clocks
// - Load HL immediate, L then H, 11 clocks
// - Load word immediate, low then high, 13 clocks
// - Store byte register at (HL), 6 clocks
// - I/O prefix redirects only memory side
// - Alternate prefix sends result to alternates
`timescale 1ns/100ps
module load_instr_operand_decode
    import ldst_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     sys_rst,
    input  wire logic     clkEn,
    input  wire logic     cmdValid,
    input  wire cmd_t     cmd,
    input  wire logic [7:0] memRdData,
    output logic          cmdReady,
    output logic          done,
    output logic          illegal,
    output memreq_t       mem,
    output evalres_t      evalRes,
    output regview_t      regView
);

    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_RUN  = 1'b1
    } state_t;

    // Register file: primary and alternate byte banks, plus 16-bit regs
    logic [7:0][7:0] mainBank_reg, mainBank_next;
    logic [7:0][7:0] altBank_reg,  altBank_next;
    logic [15:0]     ix_reg, ix_next;
    logic [15:0]     iy_reg, iy_next;
    logic [15:0]     sp_reg, sp_next;

    state_t          state_reg, state_next;
    logic [3:0]      cnt_reg, cnt_next;
    logic [3:0]      total_reg, total_next;
    cmd_t            cur_reg, cur_next;
    logic [15:0]     addr_reg, addr_next;
    logic [15:0]     wdata_reg, wdata_next;
    logic [15:0]     rdBuf_reg, rdBuf_next;
    logic            nBytes2_reg, nBytes2_next;
    logic            isWrite_reg, isWrite_next;
    logic            rdByte_reg, rdByte_next;
    logic            cmdReady_reg, cmdReady_next;
    logic            done_reg, done_next;
    logic            illegal_reg, illegal_next;
    memreq_t         mem_reg, mem_next;
    evalres_t        eval_reg, eval_next;

    function automatic logic condTest(input logic [2:0] code, input logic [7:0] fl);
        logic r;
        r = 1'b0;
        unique case (code)
            3'h0: r = ~fl[FLAG_Z];
            3'h1: r = fl[FLAG_Z];
            3'h2: r = ~fl[FLAG_C];
            3'h3: r = fl[FLAG_C];
            3'h4: r = ~fl[FLAG_LV];
            3'h5: r = fl[FLAG_LV];
            3'h6: r = ~fl[FLAG_S];
            3'h7: r = fl[FLAG_S];
        endcase
        return r;
    endfunction

    function automatic word_t decodeWord(input wsel_t sel, input logic [1:0] code);
        word_t w;
        w = W_BC;
        unique case (code)
            2'h0: w = W_BC;
            2'h1: w = W_DE;
            2'h2: begin
                unique case (sel)
                    SEL_XX:  w = W_IX;
                    SEL_YY:  w = W_IY;
                    default: w = W_HL;
                endcase
            end
            2'h3: w = (sel == SEL_ZZ) ? W_AF : W_SP;
        endcase
        return w;
    endfunction

    // High and low byte slots of a pair register
    function automatic logic [5:0] pairSlots(input word_t w);
        logic [5:0] s;
        s = {IDX_B, IDX_C};
        unique case (w)
            W_DE:    s = {IDX_D, IDX_E};
            W_HL:    s = {IDX_H, IDX_L};
            W_AF:    s = {IDX_A, IDX_F};
            default: s = {IDX_B, IDX_C};
        endcase
        return s;
    endfunction

    // Displacement is sign-extended before the add
    function automatic logic [15:0] addSigned(input logic [15:0] base, input logic [7:0] d);
        return base + {{8{d[7]}}, d};
    endfunction

    function automatic logic [15:0] readWord(input word_t w, input logic [7:0][7:0] bank,
                                             input logic [15:0] ixv, input logic [15:0] iyv,
                                             input logic [15:0] spv);
        logic [5:0] s;
        logic [15:0] v;
        s = pairSlots(w);
        v = {bank[s[5:3]], bank[s[2:0]]};
        unique case (w)
            W_SP:    v = spv;
            W_IX:    v = ixv;
            W_IY:    v = iyv;
            default: v = {bank[s[5:3]], bank[s[2:0]]};
        endcase
        return v;
    endfunction

    logic [15:0] mnAddr;
    logic [15:0] hlMain;
    logic [15:0] idxBase;
    word_t       cmdWord;
    word_t       curWord;
    logic [5:0]  curSlots;
    logic [15:0] rdWord;

    always_comb begin
        mnAddr  = {cmd.immHi, cmd.immLo};
        hlMain  = {mainBank_reg[IDX_H], mainBank_reg[IDX_L]};
        idxBase = cmd.idxY ? iy_reg : ix_reg;
        cmdWord = decodeWord(cmd.wsel, cmd.code2);
        curWord = decodeWord(cur_reg.wsel, cur_reg.code2);
        curSlots = pairSlots(curWord);
        // Second byte captured lands in the high byte, above the first
        rdWord  = rdBuf_reg;

        state_next    = state_reg;
        cnt_next      = cnt_reg;
        total_next    = total_reg;
        cur_next      = cur_reg;
        addr_next     = addr_reg;
        wdata_next    = wdata_reg;
        rdBuf_next    = rdBuf_reg;
        nBytes2_next  = nBytes2_reg;
        isWrite_next  = isWrite_reg;
        rdByte_next   = rdByte_reg;
        mainBank_next = mainBank_reg;
        altBank_next  = altBank_reg;
        ix_next       = ix_reg;
        iy_next       = iy_reg;
        sp_next       = sp_reg;
        done_next     = 1'b0;
        illegal_next  = 1'b0;
        eval_next     = eval_reg;
        mem_next      = mem_reg;
        mem_next.req  = 1'b0;
        mem_next.we   = 1'b0;

        unique case (state_reg)
            S_IDLE: begin
                if (cmdValid) begin
                    state_next   = S_RUN;
                    cnt_next     = CNT_START;
                    cur_next     = cmd;
                    addr_next    = mnAddr;
                    wdata_next   = '0;
                    nBytes2_next = 1'b0;
                    isWrite_next = 1'b0;
                    total_next   = CLK_EVAL;
                    unique case (cmd.op)
                        OP_ST_HL_IMM: begin
                            total_next   = CLK_ST_HL_IMM;
                            wdata_next   = hlMain;
                            nBytes2_next = 1'b1;
                            isWrite_next = 1'b1;
                        end
                        OP_ST_WORD_IMM: begin
                            total_next   = CLK_ST_WORD_IMM;
                            wdata_next   = readWord(cmdWord, mainBank_reg, ix_reg, iy_reg, sp_reg);
                            nBytes2_next = 1'b1;
                            isWrite_next = 1'b1;
                        end
                        OP_LD_HL_IMM: begin
                            total_next   = CLK_LD_HL_IMM;
                            nBytes2_next = 1'b1;
                        end
                        OP_LD_WORD_IMM: begin
                            total_next   = CLK_LD_WORD_IMM;
                            nBytes2_next = 1'b1;
                        end
                        OP_ST_R_HL: begin
                            total_next   = CLK_ST_R_HL;
                            addr_next    = hlMain;
                            wdata_next   = {8'h00, mainBank_reg[cmd.code3]};
                            isWrite_next = 1'b1;
                        end
                        OP_LD_R_IDX: begin
                            total_next   = CLK_LD_R_IDX;
                            addr_next    = addSigned(idxBase, cmd.disp);
                        end
                        OP_ST_R_IDX: begin
                            total_next   = CLK_ST_R_IDX;
                            addr_next    = addSigned(idxBase, cmd.disp);
                            wdata_next   = {8'h00, mainBank_reg[cmd.code3]};
                            isWrite_next = 1'b1;
                        end
                        OP_MOV_ALT: total_next = CLK_MOV_ALT;
                        default:    total_next = CLK_EVAL;
                    endcase
                end
            end
            S_RUN: begin
                cnt_next = cnt_reg + 4'h1;
                // Byte accesses; memory side only goes to I/O under the prefix
                if (cur_reg.op != OP_MOV_ALT && cur_reg.op != OP_EVAL) begin
                    if (cnt_reg == CNT_BYTE0 || (cnt_reg == CNT_BYTE1 && nBytes2_reg)) begin
                        mem_next.req   = 1'b1;
                        mem_next.we    = isWrite_reg;
                        mem_next.io    = cur_reg.ioPrefix;
                        // Low byte first at the address, high byte one above
                        mem_next.addr  = (cnt_reg == CNT_BYTE0) ? addr_reg
                                                                : addr_reg + 16'h0001;
                        mem_next.wdata = (cnt_reg == CNT_BYTE0) ? wdata_reg[7:0]
                                                                : wdata_reg[15:8];
                        rdByte_next    = (cnt_reg == CNT_BYTE1);
                    end
                end
                // Read data is taken in the cycle the request is presented
                if (mem_reg.req && !mem_reg.we) begin
                    if (rdByte_reg) begin
                        rdBuf_next[15:8] = memRdData;
                    end else begin
                        rdBuf_next[7:0] = memRdData;
                    end
                end
                if (cnt_reg == total_reg - 4'h1) begin
                    state_next = S_IDLE;
                    done_next  = 1'b1;
                    unique case (cur_reg.op)
                        OP_LD_HL_IMM: begin
                            // L from the address, H from the next one
                            if (cur_reg.altPrefix) begin
                                altBank_next[IDX_L] = rdWord[7:0];
                                altBank_next[IDX_H] = rdWord[15:8];
                            end else begin
                                mainBank_next[IDX_L] = rdWord[7:0];
                                mainBank_next[IDX_H] = rdWord[15:8];
                            end
                        end
                        OP_LD_WORD_IMM: begin
                            unique case (curWord)
                                W_SP: sp_next = rdWord;
                                W_IX: ix_next = rdWord;
                                W_IY: iy_next = rdWord;
                                default: begin
                                    if (cur_reg.altPrefix) begin
                                        altBank_next[curSlots[5:3]] = rdWord[15:8];
                                        altBank_next[curSlots[2:0]] = rdWord[7:0];
                                    end else begin
                                        mainBank_next[curSlots[5:3]] = rdWord[15:8];
                                        mainBank_next[curSlots[2:0]] = rdWord[7:0];
                                    end
                                end
                            endcase
                        end
                        OP_LD_R_IDX: begin
                            // Byte code 110 names no register: nothing is written
                            if (cur_reg.code3 == IDX_NONE) begin
                                illegal_next = 1'b1;
                            end else if (cur_reg.altPrefix) begin
                                altBank_next[cur_reg.code3] = rdWord[7:0];
                            end else begin
                                mainBank_next[cur_reg.code3] = rdWord[7:0];
                            end
                        end
                        OP_ST_R_HL, OP_ST_R_IDX: begin
                            // The write has gone out; flag a source code of 110
                            illegal_next = (cur_reg.code3 == IDX_NONE);
                        end
                        OP_MOV_ALT: begin
                            if (cur_reg.code2 == ALT_UNDEF) begin
                                illegal_next = 1'b1;
                            end else begin
                                altBank_next[{cur_reg.code2, 1'b0}] =
                                    mainBank_reg[cur_reg.code3[0] ? IDX_D : IDX_B];
                                altBank_next[{cur_reg.code2, 1'b1}] =
                                    mainBank_reg[cur_reg.code3[0] ? IDX_E : IDX_C];
                            end
                        end
                        OP_EVAL: begin
                            eval_next.condTrue = cur_reg.cond3
                                ? condTest(cur_reg.code3, mainBank_reg[IDX_F])
                                : condTest({1'b0, cur_reg.code2}, mainBank_reg[IDX_F]);
                            eval_next.bitMask = 8'h01 << cur_reg.code3;
                            eval_next.rstAddr = {9'h000, cur_reg.code3, 4'h0};
                            eval_next.branchTarget = addSigned(cur_reg.pc, cur_reg.disp);
                            illegal_next = cur_reg.code3 == RST_ILLEGAL0 ||
                                           cur_reg.code3 == RST_ILLEGAL1 ||
                                           cur_reg.code3 == RST_ILLEGAL6;
                        end
                        default: ;
                    endcase
                end
            end
        endcase
        cmdReady_next = (state_next == S_IDLE);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg    <= S_IDLE;
            cnt_reg      <= '0;
            total_reg    <= '0;
            cur_reg      <= '0;
            addr_reg     <= '0;
            wdata_reg    <= '0;
            rdBuf_reg    <= '0;
            nBytes2_reg  <= 1'b0;
            isWrite_reg  <= 1'b0;
            rdByte_reg   <= 1'b0;
            mainBank_reg <= '0;
            altBank_reg  <= '0;
            ix_reg       <= '0;
            iy_reg       <= '0;
            sp_reg       <= '0;
            cmdReady_reg <= 1'b0;
            done_reg     <= 1'b0;
            illegal_reg  <= 1'b0;
            mem_reg      <= '0;
            eval_reg     <= '0;
        end else if (clkEn) begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            total_reg    <= total_next;
            cur_reg      <= cur_next;
            addr_reg     <= addr_next;
            wdata_reg    <= wdata_next;
            rdBuf_reg    <= rdBuf_next;
            nBytes2_reg  <= nBytes2_next;
            isWrite_reg  <= isWrite_next;
            rdByte_reg   <= rdByte_next;
            mainBank_reg <= mainBank_next;
            altBank_reg  <= altBank_next;
            ix_reg       <= ix_next;
            iy_reg       <= iy_next;
            sp_reg       <= sp_next;
            cmdReady_reg <= cmdReady_next;
            done_reg     <= done_next;
            illegal_reg  <= illegal_next;
            mem_reg      <= mem_next;
            eval_reg     <= eval_next;
        end
    end

    assign cmdReady   = cmdReady_reg;
    assign done       = done_reg;
    assign illegal    = illegal_reg;
    assign mem        = mem_reg;
    assign evalRes    = eval_reg;
    assign regView.bc = {mainBank_reg[IDX_B], mainBank_reg[IDX_C]};
    assign regView.de = {mainBank_reg[IDX_D], mainBank_reg[IDX_E]};
    assign regView.hl = {mainBank_reg[IDX_H], mainBank_reg[IDX_L]};
    assign regView.af = {mainBank_reg[IDX_A], mainBank_reg[IDX_F]};
    assign regView.ix = ix_reg;
    assign regView.iy = iy_reg;
    assign regView.sp = sp_reg;

endmodule // load_instr_operand_decode

// file: ldst_pkg.sv
package ldst_pkg;

    // Clock counts per instruction form
    localparam logic [3:0] CLK_ST_HL_IMM   = 4'hD;
    localparam logic [3:0] CLK_ST_WORD_IMM = 4'hF;
    localparam logic [3:0] CLK_LD_HL_IMM   = 4'hB;
    localparam logic [3:0] CLK_LD_WORD_IMM = 4'hD;
    localparam logic [3:0] CLK_ST_R_HL     = 4'h6;
    localparam logic [3:0] CLK_LD_R_IDX    = 4'h9;
    localparam logic [3:0] CLK_ST_R_IDX    = 4'hA;
    localparam logic [3:0] CLK_MOV_ALT     = 4'h4;
    localparam logic [3:0] CLK_EVAL        = 4'h2;

    // Counter values at which the two byte accesses are launched
    localparam logic [3:0] CNT_START = 4'h1;
    localparam logic [3:0] CNT_BYTE0 = 4'h1;
    localparam logic [3:0] CNT_BYTE1 = 4'h2;

    // Byte register slots, indexed by the byte-register field
    localparam logic [2:0] IDX_B    = 3'h0;
    localparam logic [2:0] IDX_C    = 3'h1;
    localparam logic [2:0] IDX_D    = 3'h2;
    localparam logic [2:0] IDX_E    = 3'h3;
    localparam logic [2:0] IDX_H    = 3'h4;
    localparam logic [2:0] IDX_L    = 3'h5;
    localparam logic [2:0] IDX_NONE = 3'h6;
    localparam logic [2:0] IDX_A    = 3'h7;

    // Flag bit positions and the flag slot that shares the unused byte code
    localparam int FLAG_S  = 7;
    localparam int FLAG_Z  = 6;
    localparam int FLAG_LV = 2;
    localparam int FLAG_C  = 0;
    localparam logic [2:0] IDX_F = IDX_NONE;

    localparam logic [2:0]  RST_ILLEGAL0 = 3'h0;
    localparam logic [2:0]  RST_ILLEGAL1 = 3'h1;
    localparam logic [2:0]  RST_ILLEGAL6 = 3'h6;
    localparam int          RST_SHIFT    = 4;
    localparam logic [1:0]  ALT_UNDEF    = 2'h3;

    typedef enum logic [3:0] {
        OP_ST_HL_IMM   = 4'h0,
        OP_ST_WORD_IMM = 4'h1,
        OP_LD_HL_IMM   = 4'h2,
        OP_LD_WORD_IMM = 4'h3,
        OP_ST_R_HL     = 4'h4,
        OP_LD_R_IDX    = 4'h5,
        OP_ST_R_IDX    = 4'h6,
        OP_MOV_ALT     = 4'h7,
        OP_EVAL        = 4'h8
    } op_t;

    // Which word-register table the 2-bit field is read against
    typedef enum logic [1:0] {
        SEL_SS = 2'h0,
        SEL_XX = 2'h1,
        SEL_YY = 2'h2,
        SEL_ZZ = 2'h3
    } wsel_t;

    typedef enum logic [2:0] {
        W_BC = 3'h0,
        W_DE = 3'h1,
        W_HL = 3'h2,
        W_SP = 3'h3,
        W_IX = 3'h4,
        W_IY = 3'h5,
        W_AF = 3'h6
    } word_t;

    typedef struct packed {
        op_t        op;
        wsel_t      wsel;
        logic [2:0] code3;
        logic [1:0] code2;
        logic       cond3;
        logic       idxY;
        logic [7:0] immLo;
        logic [7:0] immHi;
        logic [7:0] disp;
        logic [15:0] pc;
        logic       ioPrefix;
        logic       altPrefix;
    } cmd_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        io;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } memreq_t;

    typedef struct packed {
        logic        condTrue;
        logic [7:0]  bitMask;
        logic [15:0] rstAddr;
        logic [15:0] branchTarget;
    } evalres_t;

    typedef struct packed {
        logic [15:0] bc;
        logic [15:0] de;
        logic [15:0] hl;
        logic [15:0] af;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [15:0] sp;
    } regview_t;

endpackage

// file: ldst_checker_sva.sv
`timescale 1ns/100ps
module ldst_checker
    import ldst_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       clkEn,
    input wire logic       cmdValid,
    input wire cmd_t       cmd,
    input wire logic [7:0] memRdData,
    input wire logic       cmdReady,
    input wire logic       done,
    input wire logic       illegal,
    input wire memreq_t    mem,
    input wire evalres_t   evalRes,
    input wire regview_t   regView
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic take;
    logic ioHold_reg;
    logic ioHold_next;
    assign take = clkEn && cmdValid && cmdReady;
    always_comb begin
        ioHold_next = take ? cmd.ioPrefix : ioHold_reg;
    end
    always_ff @(posedge clk_sys) begin
        ioHold_reg <= ioHold_next;
    end
    sequence evalTake;
        take && cmd.op == OP_EVAL ##1 clkEn;
    endsequence
    sequence wordWrite;
        // A frozen edge holds the request, so only an enabled edge may advance it
        mem.req && mem.we && clkEn ##1 mem.req && mem.we;
    endsequence
    done_pulse_a: assert property (done && clkEn |=> !done) else $error("done too long");
    ready_done_a: assert property (done |-> cmdReady) else $error("not ready at done");
    illegal_done_a: assert property (illegal |-> done) else $error("illegal without done");
    busy_take_a: assert property (take |=> !cmdReady) else $error("ready after take");
    eval_time_a: assert property (evalTake |=> done) else $error("eval late");
    high_next_a: assert property (wordWrite |-> mem.addr == $past(mem.addr) + 16'h0001)
        else $error("high byte misplaced");
    io_side_a: assert property (mem.req |-> mem.io == ioHold_reg) else $error("io side");
    eval_hold_a: assert property (!done |-> $stable(evalRes)) else $error("eval changed");
    rst_vec_a: assert property (evalRes.rstAddr[3:0] == 4'h0 && evalRes.rstAddr[15:7] == 9'h000)
        else $error("restart address form");
    bit_onehot_a: assert property ($onehot0(evalRes.bitMask)) else $error("bit mask");
endmodule // ldst_checker

// file: ldst_mem_model.sv
`timescale 1ns/100ps
module ldst_mem_model
    import ldst_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire memreq_t mem,
    output logic [7:0]   memRdData
);
    logic [7:0] store [0:511];
    logic [7:0] last;
    logic       ioSeen;
    initial begin
        for (int i = 0; i < 512; i++) begin
            store[i] = 8'(i * 3 + 1);
        end
        last = 8'h00;
        ioSeen = 1'b0;
    end
    // Outside a read the bus shows the inverse of the last byte, never a stale copy
    assign memRdData = (mem.req && !mem.we) ? store[mem.addr[8:0]] : ~last;
    always @(posedge clk_sys) begin
        if (mem.req) begin
            ioSeen <= mem.io;
            if (mem.we) store[mem.addr[8:0]] <= mem.wdata;
            else last <= store[mem.addr[8:0]];
        end
    end
endmodule // ldst_mem_model

// file: load_instr_operand_decode_tb.sv
`timescale 1ns/100ps
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, x, y); end end
module load_instr_operand_decode_tb;
    import ldst_pkg::*;
    logic       clk_sys;
    logic       sys_rst;
    logic       clkEn;
    logic       cmdValid;
    cmd_t       cmd;
    logic [7:0] memRdData;
    logic       cmdReady;
    logic       done;
    logic       illegal;
    memreq_t    mem;
    evalres_t   evalRes;
    regview_t   regView;
    int         n_fail = 0;
    int         checks = 0;
    int         cycles = 0;
    load_instr_operand_decode uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .cmdValid(cmdValid), .cmd(cmd), .memRdData(memRdData), .cmdReady(cmdReady),
        .done(done), .illegal(illegal), .mem(mem), .evalRes(evalRes), .regView(regView));
    ldst_mem_model mdl (.clk_sys(clk_sys), .mem(mem), .memRdData(memRdData));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end
    function automatic logic [7:0] f(input int a);
        return 8'(a * 3 + 1);
    endfunction
    function automatic cmd_t mk(op_t op, wsel_t w, logic [2:0] c3, logic [1:0] c2,
                                logic [15:0] mn);
        cmd_t c;
        c = '0;
        c.op = op;
        c.wsel = w;
        c.code3 = c3;
        c.code2 = c2;
        c.immLo = mn[7:0];
        c.immHi = mn[15:8];
        return c;
    endfunction
    task automatic issue(input cmd_t c, input int n);
        int k;
        // The take edge is the first clock of the instruction
        k = 1;
        @(negedge clk_sys);
        while (cmdReady !== 1'b1) @(negedge clk_sys);
        cmd = c;
        cmdValid = 1'b1;
        @(negedge clk_sys);
        cmdValid = 1'b0;
        // Ops other than OP_EVAL see one frozen edge, which must not count
        if (c.op != OP_EVAL) begin
            clkEn = 1'b0;
            @(negedge clk_sys);
            clkEn = 1'b1;
        end
        while (done !== 1'b1 && k < 40) begin
            @(negedge clk_sys);
            k++;
        end
        `CHK(k, n)
    endtask
    task automatic t_words();
        cmd_t c;
        issue(mk(OP_LD_WORD_IMM, SEL_SS, 3'h0, 2'h1, 16'h00FF), 13);
        `CHK(regView.de, {f(9'h100), f(9'h0FF)})
        c = mk(OP_ST_WORD_IMM, SEL_SS, 3'h0, 2'h1, 16'h0040);
        c.ioPrefix = 1'b1;
        issue(c, 15);
        `CHK({mdl.store[9'h041], mdl.store[9'h040]}, regView.de)
        `CHK(mdl.ioSeen, 1'b1)
        issue(mk(OP_LD_WORD_IMM, SEL_XX, 3'h0, 2'h2, 16'h0010), 13);
        `CHK(regView.ix, 16'h3431)
        issue(mk(OP_ST_WORD_IMM, SEL_XX, 3'h0, 2'h2, 16'h0050), 15);
        `CHK({mdl.store[9'h051], mdl.store[9'h050]}, regView.ix)
        `CHK(mdl.ioSeen, 1'b0)
    endtask
    task automatic t_hl();
        cmd_t c;
        issue(mk(OP_LD_HL_IMM, SEL_SS, 3'h0, 2'h0, 16'h0080), 11);
        `CHK(regView.hl, {f(9'h081), f(9'h080)})
        c = mk(OP_LD_HL_IMM, SEL_SS, 3'h0, 2'h0, 16'h0000);
        c.altPrefix = 1'b1;
        issue(c, 11);
        `CHK(regView.hl, {f(9'h081), f(9'h080)})
        issue(mk(OP_ST_R_HL, SEL_SS, 3'h5, 2'h0, 16'h0000), 6);
        `CHK(mdl.store[regView.hl[8:0]], regView.hl[7:0])
        issue(mk(OP_ST_HL_IMM, SEL_SS, 3'h0, 2'h0, 16'h0060), 13);
        `CHK({mdl.store[9'h061], mdl.store[9'h060]}, regView.hl)
    endtask
    task automatic t_eval();
        cmd_t c;
        // Flags 44h: zero and logical check set, sign and carry clear
        issue(mk(OP_LD_WORD_IMM, SEL_ZZ, 3'h0, 2'h3, 16'h00C1), 13);
        `CHK(regView.af, 16'h4744)
        for (int i = 0; i < 8; i++) begin
            c = mk(OP_EVAL, SEL_SS, 3'(i), 2'(i), 16'h0000);
            c.cond3 = 1'b1;
            c.pc = 16'h1000;
            c.disp = 8'h80;
            issue(c, 2);
            `CHK(illegal, 1'(i == 0 || i == 1 || i == 6))
            `CHK(evalRes.bitMask, 8'(8'h01 << i))
            `CHK(evalRes.rstAddr, {9'h000, 3'(i), 4'h0})
            `CHK(evalRes.branchTarget, 16'h0F80)
            `CHK(evalRes.condTrue, 1'(8'h66 >> i))
            c.cond3 = 1'b0;
            issue(c, 2);
            `CHK(evalRes.condTrue, 1'(8'h66 >> c.code2))
        end
    endtask
    task automatic t_idx();
        cmd_t c;
        // IX is 3431h here, so the byte lands at 3421h
        c = mk(OP_ST_R_IDX, SEL_SS, 3'h7, 2'h0, 16'h0000);
        c.disp = 8'hF0;
        issue(c, 10);
        `CHK(mdl.store[9'h021], 8'h47)
        c.op = OP_LD_R_IDX;
        c.code3 = 3'h0;
        issue(c, 9);
        `CHK(regView.bc[15:8], 8'h47)
        c.code3 = 3'h6;
        issue(c, 9);
        `CHK(illegal, 1'b1)
        issue(mk(OP_MOV_ALT, SEL_SS, 3'h0, 2'h3, 16'h0000), 4);
        `CHK(illegal, 1'b1)
    endtask
    task automatic summarize();
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        cmdValid = 1'b0;
        cmd = '0;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_words();
        t_hl();
        t_eval();
        t_idx();
        summarize();
    end
endmodule // load_instr_operand_decode_tb
bind load_instr_operand_decode ldst_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clkEn(clkEn), .cmdValid(cmdValid), .cmd(cmd), .memRdData(memRdData),
    .cmdReady(cmdReady), .done(done), .illegal(illegal), .mem(mem), .evalRes(evalRes),
    .regView(regView));
